// [common/uart_pkg.sv]
// Package: register map, reset values, types for the serial channel
`default_nettype none
package uart_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] OFS_DATA = 8'h00;
   localparam logic [7:0] OFS_IER  = 8'h04;
   localparam logic [7:0] OFS_FCR  = 8'h08;
   localparam logic [7:0] OFS_ISR  = 8'h0C;
   localparam logic [7:0] OFS_LCR  = 8'h10;
   localparam logic [7:0] OFS_MCR  = 8'h14;
   localparam logic [7:0] OFS_LSR  = 8'h18;
   localparam logic [7:0] OFS_EFR  = 8'h1C;
   localparam logic [7:0] OFS_TCR  = 8'h20;
   localparam logic [7:0] OFS_DLD  = 8'h24;
   localparam logic [7:0] OFS_XCH  = 8'h28;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int IER_RX = 0, IER_TX = 1, IER_XOFF = 5, IER_RTS = 6, IER_CTS = 7;
   localparam int EFR_SWRX = 0, EFR_DBL = 1, EFR_SWTX = 2, EFR_ENH = 4;
   localparam int EFR_ARTS = 6, EFR_ACTS = 7;
   localparam int LCR_STOP2 = 2, LCR_PEN = 3, LCR_EVEN = 4;
   localparam int FCR_EN = 0, MCR_RTS = 1, DLD_485 = 6;
   // ----------------------------------------
   // Codes and counts
   // ----------------------------------------
   localparam logic [1:0] SMP_8X   = 2'b01;
   localparam logic [1:0] SMP_4X   = 2'b10;
   localparam logic [3:0] LAST_16X = 4'hF;
   localparam logic [3:0] LAST_8X  = 4'h7;
   localparam logic [3:0] LAST_4X  = 4'h3;
   localparam logic [3:0] HALF_16X = 4'h7;
   localparam logic [3:0] HALF_8X  = 4'h3;
   localparam logic [3:0] HALF_4X  = 4'h1;
   localparam logic [5:0] TO_BASE  = 6'h20;
   localparam logic [6:0] FIFO_CAP = 7'h40;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP} ser_state_t;
   typedef struct packed {
      logic psel; logic penable; logic pwrite; logic [7:0] paddr; logic [31:0] pwdata;
   } apb_req_t;
   typedef struct packed {logic brk; logic ferr; logic perr; logic [7:0] data;} rx_word_t;
   typedef struct packed {
      ser_state_t st; logic [3:0] tick; logic [2:0] bitn; logic [7:0] sh;
      logic par; logic stop2; logic out; logic [5:0] wp; logic [5:0] rp; logic [6:0] cnt;
   } tx_st_t;
   typedef struct packed {
      ser_state_t st; logic [3:0] tick; logic [2:0] bitn; logic [7:0] sh; logic perr;
      logic [5:0] wp; logic [5:0] rp; logic [6:0] cnt; logic [3:0] to_tick;
      logic [5:0] to_bits; logic to; logic hold_v; rx_word_t hold; logic dfr_v;
      rx_word_t dfr;
   } rx_st_t;
   typedef struct packed {
      logic [7:0] interrupt_enable; logic [21:0] fifo_control; logic [4:0] line_control; logic rts_req; logic [7:0] enhanced_feature;
      logic [7:0] halt_resume_levels; logic [7:0] divisor_fraction; logic [31:0] xch; logic [31:0] prdata;
      logic pready; logic pslverr; logic pop_ok; logic flow_flag; logic xoff_flag;
      logic sw_halt; logic rts_halt; logic local_off; logic [1:0] ctl_pend;
      logic rts_n; logic irq;
   } regs_t;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [4:0]  LCR_RST = 5'h03;
   localparam logic [7:0]  TCR_RST = 8'h2F;
   localparam logic [31:0] XCH_RST = 32'h0000_0000;
   localparam tx_st_t TX_RST = '{st: S_IDLE, out: 1'b1, default: '0};
   localparam rx_st_t RX_RST = '{st: S_IDLE, hold: '0, dfr: '0, default: '0};
   localparam regs_t REGS_RST = '{line_control: LCR_RST, halt_resume_levels: TCR_RST, xch: XCH_RST,
                                  rts_n: 1'b1, default: '0};
endpackage : uart_pkg
`default_nettype wire

// [tb/uart_channel_props.sv]
// Checker: bus handshake and serial bit timing at the channel ports
`default_nettype none
module uart_channel_props
   import uart_pkg::*;
(
   // Clock, reset and bus
   input wire logic        mclk_in,
   input wire logic        rst_in,
   input wire apb_req_t    apb_in,
   input wire logic [31:0] prdata_out,
   input wire logic        pready_out,
   input wire logic        pslverr_out,
   // Serial side
   input wire logic        tx_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (rst_in);
   // ----
   // Steps
   // ----
   sequence s_acc;
      apb_in.psel && apb_in.penable && !pready_out;
   endsequence
   sequence s_hold;
      $stable(tx_out) [*3];
   endsequence
   property p_rdy_lat; s_acc |=> pready_out; endproperty
   property p_rdy_pls; pready_out |=> !pready_out; endproperty
   property p_err_pls; pslverr_out |-> pready_out; endproperty
   property p_err_dat; pready_out && pslverr_out |-> prdata_out == 32'h0000_0000; endproperty
   property p_err_map;
      pready_out && apb_in.paddr[1:0] == 2'h0 |-> pslverr_out == (apb_in.paddr > OFS_XCH);
   endproperty
   property p_rd_hold; !pready_out |-> $stable(prdata_out); endproperty
   property p_bit_min; $changed(tx_out) |=> s_hold; endproperty
   property p_stop_due; $fell(tx_out) |-> ##[1:161] tx_out; endproperty
   a_rdy_lat: assert property (p_rdy_lat) else $error("ready late");
   a_rdy_pls: assert property (p_rdy_pls) else $error("ready too long");
   a_err_pls: assert property (p_err_pls) else $error("error without ready");
   a_err_dat: assert property (p_err_dat) else $error("error with data");
   a_err_map: assert property (p_err_map) else $error("error flag wrong");
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   a_bit_min: assert property (p_bit_min) else $error("bit too short");
   a_stop_due: assert property (p_stop_due) else $error("no stop bit");
endmodule : uart_channel_props
bind uart_channel uart_channel_props props_u (
   .mclk_in     (mclk_in),
   .rst_in      (rst_in),
   .apb_in      (apb_in),
   .prdata_out  (prdata_out),
   .pready_out  (pready_out),
   .pslverr_out (pslverr_out),
   .tx_out      (tx_out)
);
`default_nettype wire

// [tb/uart_channel_tb.sv]
// Testbench: registers, framing per sampling mode, receive path, software flow
`default_nettype none
module uart_channel_tb import uart_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk_in;
   logic        rst_in;
   apb_req_t    apb_in;
   logic [31:0] prdata_out;
   logic        pready_out;
   logic        pslverr_out;
   logic        rx_in;
   logic        tx_out;
   logic        rts_n_out;
   logic        cts_n_in;
   logic        int_out;
   logic [31:0] q;
   logic        e;
   logic [9:0]  f;
   int          n_errors = 0;
   int          num_checks = 0;
   int          cyc = 0;
   uart_channel dut_u (.mclk_in(mclk_in), .rst_in(rst_in), .apb_in(apb_in),
      .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
      .rx_in(rx_in), .cts_n_in(cts_n_in), .tx_out(tx_out), .rts_n_out(rts_n_out),
      .int_out(int_out));
   uart_remote remote_u (.clk_in(mclk_in), .rts_n_in(rts_n_out), .line_out(rx_in));
   initial begin
      mclk_in = 1'b0;
      forever #50 mclk_in = ~mclk_in;
   end
   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : finish_test
   always @(posedge mclk_in) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_errors++;
         finish_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask : chk
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge mclk_in);
      apb_in <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge mclk_in);
      apb_in.penable <= 1'b1;
      do begin
         @(posedge mclk_in);
      end while (pready_out !== 1'b1);
      q = prdata_out;
      e = pslverr_out;
      apb_in <= '0;
   endtask : bus
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string m);
      bus(a, 1'b0, 32'h0000_0000);
      chk(q, exp, m);
   endtask : rd
   task automatic get_frame(input int bt);
      while (tx_out !== 1'b0) @(posedge mclk_in);
      repeat (bt / 2) @(posedge mclk_in);
      for (int i = 0; i < 10; i++) begin
         f[i] = tx_out;
         repeat (bt) @(posedge mclk_in);
      end
   endtask : get_frame
   initial begin
      rst_in = 1'b1;
      cts_n_in = 1'b0;
      apb_in = '0;
      repeat (12) @(posedge mclk_in);
      rst_in <= 1'b0;
      rd(OFS_XCH, 32'h0000_0000, "flow chars reset");
      bus(OFS_XCH, 1'b1, 32'h0013_0011);
      rd(OFS_XCH, 32'h0013_0011, "flow chars write");
      rd(8'h2C, 32'h0000_0000, "unmapped data");
      chk(32'(e), 32'h0000_0001, "unmapped error");
      bus(OFS_FCR, 1'b1, 32'h0000_0001);
      bus(OFS_MCR, 1'b1, 32'h0000_0002);
      repeat (2) @(posedge mclk_in);
      chk(32'(rts_n_out), 32'h0000_0000, "request to send");
      rd(OFS_LSR, 32'h0000_0060, "idle status");
      for (int m = 0; m < 3; m++) begin
         bus(OFS_DLD, 1'b1, 32'(m << 4));
         fork
            begin
               bus(OFS_DATA, 1'b1, 32'(8'hA0 + m));
               rd(OFS_LSR, 32'h0000_0020, "busy status");
            end
            get_frame(16 >> m);
         join
         chk(32'(f), 32'({1'b1, 8'(8'hA0 + m), 1'b0}), "frame");
         remote_u.send(8'(8'h3C + m), 16 >> m);
         repeat (8) @(posedge mclk_in);
         rd(OFS_LSR, 32'h0000_0061, "data ready");
         rd(OFS_DATA, 32'(8'h3C + m), "received byte");
         rd(OFS_LSR, 32'h0000_0060, "drained");
      end
      bus(OFS_DLD, 1'b1, 32'h0000_0000);
      bus(OFS_LCR, 1'b1, 32'h0000_001A);
      fork
         bus(OFS_DATA, 1'b1, 32'h0000_0055);
         get_frame(16);
      join
      chk(32'(f), 32'({1'b1, 1'b0, 7'h55, 1'b0}), "parity frame");
      bus(OFS_LCR, 1'b1, 32'h0000_0003);
      bus(OFS_EFR, 1'b1, 32'h0000_0011);
      bus(OFS_IER, 1'b1, 32'h0000_0020);
      remote_u.send(8'h13, 16);
      repeat (8) @(posedge mclk_in);
      rd(OFS_LSR, 32'h0000_0060, "flow char kept out");
      rd(OFS_ISR, 32'h0000_0010, "off flag");
      chk(32'(int_out), 32'h0000_0001, "off interrupt");
      bus(OFS_DATA, 1'b1, 32'h0000_0041);
      repeat (40) @(posedge mclk_in);
      chk(32'(tx_out), 32'h0000_0001, "halted");
      fork
         remote_u.send(8'h11, 16);
         get_frame(16);
      join
      chk(32'(f), 32'({1'b1, 8'h41, 1'b0}), "resumed frame");
      rd(OFS_ISR, 32'h0000_0001, "off flag cleared");
      bus(OFS_EFR, 1'b1, 32'h0000_0090);
      bus(OFS_IER, 1'b1, 32'h0000_0080);
      cts_n_in <= 1'b1;
      bus(OFS_DATA, 1'b1, 32'h0000_0027);
      repeat (40) @(posedge mclk_in);
      chk(32'(tx_out), 32'h0000_0001, "clear to send hold");
      chk(32'(int_out), 32'h0000_0001, "flow interrupt");
      rd(OFS_ISR, 32'h0000_0020, "flow flag");
      cts_n_in <= 1'b0;
      get_frame(16);
      chk(32'(f), 32'({1'b1, 8'h27, 1'b0}), "clear to send resume");
      chk(32'(int_out), 32'h0000_0000, "flow flag read clear");
      bus(OFS_TCR, 1'b1, 32'h0000_0001);
      bus(OFS_EFR, 1'b1, 32'h0000_0050);
      bus(OFS_MCR, 1'b1, 32'h0000_0002);
      bus(OFS_IER, 1'b1, 32'h0000_0040);
      bus(OFS_DLD, 1'b1, 32'h0000_0020);
      for (int k = 0; k < 4; k++) remote_u.send(8'(k), 4);
      repeat (8) @(posedge mclk_in);
      chk(32'(rts_n_out), 32'h0000_0001, "request to send halt");
      rd(OFS_ISR, 32'h0000_0020, "request flag");
      for (int k = 0; k < 4; k++) rd(OFS_DATA, 32'(k), "held data");
      repeat (2) @(posedge mclk_in);
      chk(32'(rts_n_out), 32'h0000_0000, "request to send resume");
      finish_test();
   end
endmodule : uart_channel_tb
`default_nettype wire

// [tb/uart_remote.sv]
// Partner: remote transmitter driving the channel's receive line
`default_nettype none
module uart_remote (
   // Clock and flow input
   input  wire logic clk_in,
   input  wire logic rts_n_in,
   // Serial line, idles high
   output var logic  line_out
);
   timeunit 1ns;
   timeprecision 1ns;
   initial line_out = 1'b1;
   // Start, data low bit first, one stop; holds off while flow is off
   task automatic send(input logic [7:0] b, input int bt);
      logic [9:0] fr;
      fr = {1'b1, b, 1'b0};
      while (rts_n_in !== 1'b0) @(posedge clk_in);
      for (int i = 0; i < 10; i++) begin
         @(posedge clk_in);
         line_out <= fr[i];
         repeat (bt - 1) @(posedge clk_in);
      end
   endtask : send
endmodule : uart_remote
`default_nettype wire

// [verilog/uart_channel.sv]
// Serial channel: APB registers, transmit/receive FIFOs, framing, flow control
`default_nettype none
module uart_channel
   import uart_pkg::*;
(
   // Clock and reset
   input  wire logic        mclk_in,
   input  wire logic        rst_in,
   // APB slave
   input  wire apb_req_t    apb_in,
   output logic [31:0]      prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // Serial side
   input  wire logic        rx_in,
   input  wire logic        cts_n_in,
   output logic             tx_out,
   output logic             rts_n_out,
   output logic             int_out
);
   // ----------------------------------------
   // State and shared terms
   // ----------------------------------------
   regs_t      r_q, r_d;
   tx_st_t     tx_q, t;
   rx_st_t     rx_q, x;
   logic [7:0] tx_mem [FIFO_CAP];
   rx_word_t   rx_mem [FIFO_CAP];
   logic       rx_m_q, rx_s_q, rx_p_q, cts_m_q, cts_s_q, cts_p_q;
   logic [3:0] blast, hlast;
   logic [2:0] nb_last;
   logic [7:0] mask, ld_val, rx_al, ctl_char;
   logic [6:0] cap, hlv, rlv;
   logic       fifo_en, tx_push, tx_pop, rx_pop, ctl_taken, ld, tx_halt;
   logic       acc, commit, rx_lvl, tx_lvl, tx_empty, done, push_v, push_ok;
   logic       xoff_hit, xon_hit, dbl, rts_pin, rx_any;
   logic       is_xoff1, is_xon1, pair_off, pair_on;
   rx_word_t   word, push_w, head;

   assign prdata_out  = r_q.prdata;
   assign pready_out  = r_q.pready;
   assign pslverr_out = r_q.pslverr;
   assign tx_out      = tx_q.out;
   assign rts_n_out   = r_q.rts_n;
   assign int_out     = r_q.irq;

   always_comb begin
      case (r_q.divisor_fraction[5:4])
         SMP_8X:  begin blast = LAST_8X;  hlast = HALF_8X;  end
         SMP_4X:  begin blast = LAST_4X;  hlast = HALF_4X;  end
         default: begin blast = LAST_16X; hlast = HALF_16X; end
      endcase
   end
   assign nb_last  = 3'(3'd4 + {1'b0, r_q.line_control[1:0]});
   assign mask     = 8'(8'hFF >> (2'd3 - r_q.line_control[1:0]));
   assign fifo_en  = r_q.fifo_control[FCR_EN];
   assign cap      = fifo_en ? FIFO_CAP : 7'h01;
   assign hlv      = {1'b0, r_q.halt_resume_levels[3:0], 2'b00};
   assign rlv      = {1'b0, r_q.halt_resume_levels[7:4], 2'b00};
   assign dbl      = r_q.enhanced_feature[EFR_DBL];
   assign head     = rx_mem[rx_q.rp];
   assign tx_empty = (tx_q.cnt == 7'h00) && (tx_q.st == S_IDLE);
   assign rx_any   = rx_q.cnt != 7'h00;

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   always_ff @(posedge mclk_in) begin
      rx_m_q  <= rx_in;
      rx_s_q  <= rx_m_q;
      rx_p_q  <= rx_s_q;
      cts_m_q <= cts_n_in;
      cts_s_q <= cts_m_q;
      cts_p_q <= cts_s_q;
   end

   // ----------------------------------------
   // Register file, flags, flow control
   // ----------------------------------------
   always_comb begin
      r_d       = r_q;
      r_d.pready  = 1'b0;
      r_d.pslverr = 1'b0;
      acc       = apb_in.psel && apb_in.penable;
      commit    = acc && r_q.pready;
      tx_push   = commit && apb_in.pwrite && (apb_in.paddr == OFS_DATA)
                  && (tx_q.cnt < cap);
      rx_pop    = commit && !apb_in.pwrite && (apb_in.paddr == OFS_DATA)
                  && r_q.pop_ok;
      rx_lvl    = fifo_en ? (rx_q.cnt >= {1'b0, r_q.fifo_control[13:8]})
                          : (rx_q.cnt != 7'h00);
      if (r_q.divisor_fraction[DLD_485]) tx_lvl = tx_empty;
      else if (fifo_en)     tx_lvl = tx_q.cnt < {1'b0, r_q.fifo_control[21:16]};
      else                  tx_lvl = tx_q.cnt == 7'h00;
      if (acc && !r_q.pready) begin
         r_d.pready = 1'b1;
         r_d.pop_ok = rx_q.cnt != 7'h00;
         case (apb_in.paddr)
            OFS_DATA: r_d.prdata = {24'h00_0000, head.data};
            OFS_IER:  r_d.prdata = {24'h00_0000, r_q.interrupt_enable};
            OFS_FCR:  r_d.prdata = {10'h000, r_q.fifo_control};
            OFS_ISR:  r_d.prdata = {26'h000_0000, r_q.flow_flag, r_q.xoff_flag,
                                    rx_q.to & r_q.interrupt_enable[IER_RX], rx_lvl & r_q.interrupt_enable[IER_RX],
                                    tx_lvl & r_q.interrupt_enable[IER_TX], !r_q.irq};
            OFS_LCR:  r_d.prdata = {27'h000_0000, r_q.line_control};
            OFS_MCR:  r_d.prdata = {30'h0000_0000, r_q.rts_req, 1'b0};
            OFS_LSR:  r_d.prdata = {25'h000_0000, tx_empty, tx_q.cnt == 7'h00,
                                    head.brk & rx_any, head.ferr & rx_any,
                                    head.perr & rx_any, 1'b0, rx_any};
            OFS_EFR:  r_d.prdata = {24'h00_0000, r_q.enhanced_feature};
            OFS_TCR:  r_d.prdata = {24'h00_0000, r_q.halt_resume_levels};
            OFS_DLD:  r_d.prdata = {24'h00_0000, r_q.divisor_fraction};
            OFS_XCH:  r_d.prdata = r_q.xch;
            default: begin
               r_d.prdata  = 32'h0000_0000;
               r_d.pslverr = 1'b1;
            end
         endcase
      end
      if (commit && apb_in.pwrite) begin
         case (apb_in.paddr)
            OFS_IER: begin
               r_d.interrupt_enable[3:0] = apb_in.pwdata[3:0];
               if (r_q.enhanced_feature[EFR_ENH]) r_d.interrupt_enable[7:4] = apb_in.pwdata[7:4];
            end
            OFS_FCR: r_d.fifo_control = apb_in.pwdata[21:0];
            OFS_LCR: r_d.line_control = apb_in.pwdata[4:0];
            OFS_MCR: r_d.rts_req = apb_in.pwdata[MCR_RTS];
            OFS_EFR: r_d.enhanced_feature = apb_in.pwdata[7:0];
            OFS_TCR: r_d.halt_resume_levels = apb_in.pwdata[7:0];
            OFS_DLD: r_d.divisor_fraction = apb_in.pwdata[7:0];
            OFS_XCH: r_d.xch = apb_in.pwdata;
            default: r_d.xch = r_q.xch;
         endcase
      end
      // Remote Xoff/Xon stops and restarts the transmitter
      if (xoff_hit) r_d.sw_halt = 1'b1;
      else if (xon_hit) r_d.sw_halt = 1'b0;
      if (xoff_hit && r_q.interrupt_enable[IER_XOFF]) r_d.xoff_flag = 1'b1;
      else if (xon_hit) r_d.xoff_flag = 1'b0;
      // Local receive level drives Xoff/Xon transmission
      if (ctl_taken) r_d.ctl_pend = 2'(r_q.ctl_pend - 2'd1);
      if (r_q.enhanced_feature[EFR_SWTX] && !r_q.local_off && rx_q.cnt >= hlv) begin
         r_d.local_off = 1'b1;
         r_d.ctl_pend  = dbl ? 2'd2 : 2'd1;
      end else if (r_q.local_off && rx_q.cnt <= rlv) begin
         r_d.local_off = 1'b0;
         r_d.ctl_pend  = dbl ? 2'd2 : 2'd1;
      end
      // Request-to-send pin
      if (rx_q.cnt >= hlv) r_d.rts_halt = 1'b1;
      else if (rx_q.cnt <= rlv) r_d.rts_halt = 1'b0;
      if (r_q.divisor_fraction[DLD_485])
         rts_pin = (tx_q.st != S_IDLE) || (tx_q.cnt != 7'h00);
      else if (r_q.enhanced_feature[EFR_ARTS] && r_q.rts_req)
         rts_pin = r_d.rts_halt;
      else
         rts_pin = !r_q.rts_req;
      r_d.rts_n = rts_pin;
      // Flow interrupt source, cleared by reading the source register
      if (commit && !apb_in.pwrite && apb_in.paddr == OFS_ISR) r_d.flow_flag = 1'b0;
      if ((!r_q.rts_n && rts_pin && r_q.interrupt_enable[IER_RTS])
          || (cts_s_q && !cts_p_q && r_q.interrupt_enable[IER_CTS]))
         r_d.flow_flag = 1'b1;
      r_d.irq = (r_q.interrupt_enable[IER_RX] && (rx_lvl || rx_q.to))
                || (r_q.interrupt_enable[IER_TX] && tx_lvl)
                || r_q.flow_flag || r_q.xoff_flag;
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) r_q <= REGS_RST;
      else        r_q <= r_d;
   end

   // ----------------------------------------
   // Transmitter
   // ----------------------------------------
   always_comb begin
      t         = tx_q;
      tx_pop    = 1'b0;
      ctl_taken = 1'b0;
      ld        = 1'b0;
      ld_val    = 8'h00;
      tx_halt   = (r_q.enhanced_feature[EFR_ACTS] && cts_s_q) || r_q.sw_halt;
      if (r_q.local_off)
         ctl_char = (dbl && r_q.ctl_pend == 2'd1) ? r_q.xch[31:24] : r_q.xch[23:16];
      else
         ctl_char = (dbl && r_q.ctl_pend == 2'd1) ? r_q.xch[15:8] : r_q.xch[7:0];
      if (tx_q.st != S_IDLE) t.tick = (tx_q.tick == blast) ? 4'h0 : 4'(tx_q.tick + 4'h1);
      case (tx_q.st)
         S_IDLE: begin
            t.out = 1'b1;
            if (r_q.ctl_pend != 2'd0) begin
               ld        = 1'b1;
               ld_val    = ctl_char;
               ctl_taken = 1'b1;
            end else if (tx_q.cnt != 7'h00 && !tx_halt
                         && (!r_q.divisor_fraction[DLD_485] || r_q.rts_n)) begin
               ld     = 1'b1;
               ld_val = tx_mem[tx_q.rp];
               tx_pop = 1'b1;
            end
            if (ld) begin
               t.sh    = ld_val & mask;
               t.par   = ^(ld_val & mask) ^ !r_q.line_control[LCR_EVEN];
               t.st    = S_START;
               t.out   = 1'b0;
               t.stop2 = 1'b0;
               t.tick  = 4'h0;
            end
         end
         S_START: if (tx_q.tick == blast) begin
            t.st   = S_DATA;
            t.bitn = 3'h0;
            t.out  = tx_q.sh[0];
         end
         S_DATA: if (tx_q.tick == blast) begin
            if (tx_q.bitn == nb_last) begin
               t.st  = r_q.line_control[LCR_PEN] ? S_PAR : S_STOP;
               t.out = r_q.line_control[LCR_PEN] ? tx_q.par : 1'b1;
            end else begin
               t.bitn = 3'(tx_q.bitn + 3'h1);
               t.sh   = {1'b0, tx_q.sh[7:1]};
               t.out  = tx_q.sh[1];
            end
         end
         S_PAR: if (tx_q.tick == blast) begin
            t.st  = S_STOP;
            t.out = 1'b1;
         end
         S_STOP: if (tx_q.tick == blast) begin
            if (r_q.line_control[LCR_STOP2] && !tx_q.stop2) t.stop2 = 1'b1;
            else t.st = S_IDLE;
         end
         default: t = TX_RST;
      endcase
      t.wp  = 6'(tx_q.wp + {5'h00, tx_push});
      t.rp  = 6'(tx_q.rp + {5'h00, tx_pop});
      t.cnt = 7'(tx_q.cnt + {6'h00, tx_push} - {6'h00, tx_pop});
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) tx_q <= TX_RST;
      else        tx_q <= t;
   end

   always_ff @(posedge mclk_in) begin
      if (tx_push) tx_mem[tx_q.wp] <= apb_in.pwdata[7:0];
   end

   // ----------------------------------------
   // Receiver
   // ----------------------------------------
   assign rx_al    = 8'(rx_q.sh >> (2'd3 - r_q.line_control[1:0]));
   assign is_xoff1 = rx_al == (r_q.xch[23:16] & mask);
   assign is_xon1  = rx_al == (r_q.xch[7:0] & mask);

   always_comb begin
      x        = rx_q;
      done     = 1'b0;
      word     = '{brk: !rx_s_q && rx_al == 8'h00, ferr: !rx_s_q,
                   perr: rx_q.perr, data: rx_al};
      if (rx_q.st != S_IDLE && rx_q.st != S_START)
         x.tick = (rx_q.tick == blast) ? 4'h0 : 4'(rx_q.tick + 4'h1);
      case (rx_q.st)
         S_IDLE: if (rx_p_q && !rx_s_q) begin
            x.st   = S_START;
            x.tick = 4'h0;
            x.perr = 1'b0;
         end
         S_START: begin
            x.tick = 4'(rx_q.tick + 4'h1);
            if (rx_q.tick == hlast) begin
               x.st   = rx_s_q ? S_IDLE : S_DATA;
               x.tick = 4'h0;
               x.bitn = 3'h0;
            end
         end
         S_DATA: if (rx_q.tick == blast) begin
            x.sh = {rx_s_q, rx_q.sh[7:1]};
            if (rx_q.bitn == nb_last) x.st = r_q.line_control[LCR_PEN] ? S_PAR : S_STOP;
            else x.bitn = 3'(rx_q.bitn + 3'h1);
         end
         S_PAR: if (rx_q.tick == blast) begin
            x.perr = rx_s_q ^ ^rx_al ^ !r_q.line_control[LCR_EVEN];
            x.st   = S_STOP;
         end
         S_STOP: if (rx_q.tick == blast) begin
            done = 1'b1;
            x.st = S_IDLE;
         end
         default: x.st = S_IDLE;
      endcase
      // Flow character detection and deferred pushes
      pair_off = rx_q.hold_v && rx_q.hold.data == (r_q.xch[23:16] & mask)
                 && rx_al == (r_q.xch[31:24] & mask);
      pair_on  = rx_q.hold_v && rx_q.hold.data == (r_q.xch[7:0] & mask)
                 && rx_al == (r_q.xch[15:8] & mask);
      xoff_hit = 1'b0;
      xon_hit  = 1'b0;
      push_v   = rx_q.dfr_v;
      push_w   = rx_q.dfr;
      x.dfr_v  = 1'b0;
      if (done) begin
         if (!r_q.enhanced_feature[EFR_SWRX]) begin
            push_v = 1'b1;
            push_w = word;
         end else if (!dbl) begin
            xoff_hit = is_xoff1;
            xon_hit  = is_xon1 && !is_xoff1;
            push_v   = !is_xoff1 && !is_xon1;
            push_w   = word;
         end else if (pair_off || pair_on) begin
            xoff_hit = pair_off;
            xon_hit  = pair_on && !pair_off;
            x.hold_v = 1'b0;
         end else begin
            push_v   = rx_q.hold_v;
            push_w   = rx_q.hold;
            x.hold_v = is_xoff1 || is_xon1;
            x.hold   = word;
            x.dfr_v  = !(is_xoff1 || is_xon1) && rx_q.hold_v;
            x.dfr    = word;
            if (!rx_q.hold_v && !x.hold_v) begin
               push_v = 1'b1;
               push_w = word;
            end
         end
      end
      push_ok = push_v && rx_q.cnt < cap;
      x.wp    = 6'(rx_q.wp + {5'h00, push_ok});
      x.rp    = 6'(rx_q.rp + {5'h00, rx_pop});
      x.cnt   = 7'(rx_q.cnt + {6'h00, push_ok} - {6'h00, rx_pop});
      // Receive timeout
      if (rx_q.cnt == 7'h00 || done || rx_pop) begin
         x.to_tick = 4'h0;
         x.to_bits = 6'h00;
         x.to      = 1'b0;
      end else if (!rx_q.to) begin
         x.to_tick = (rx_q.to_tick == blast) ? 4'h0 : 4'(rx_q.to_tick + 4'h1);
         if (rx_q.to_tick == blast) x.to_bits = 6'(rx_q.to_bits + 6'h01);
         x.to = rx_q.to_bits == 6'(TO_BASE + {2'b00, r_q.line_control[1:0], 2'b00});
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) rx_q <= RX_RST;
      else        rx_q <= x;
   end

   always_ff @(posedge mclk_in) begin
      if (push_ok) rx_mem[rx_q.wp] <= push_w;
   end
endmodule : uart_channel
`default_nettype wire
